/* hw/pmc_pkg.sv */
// Constants for the port mode configuration register bank
package pmc_pkg;
   // Clock and blanking step timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BLANK_STEP_US = 100;
   localparam int BLANK_STEP_CYCLES = (CLK_HZ / 1_000_000) * BLANK_STEP_US;
   // Bus geometry: word address is {logical device, register index}
   localparam int ADR_W = 18;
   localparam int DAT_W = 32;
   localparam logic [7:0] LDN_PARALLEL = 8'h03;
   localparam logic [7:0] LDN_SERIAL_ONE = 8'h04;
   localparam logic [7:0] LDN_SERIAL_TWO = 8'h05;
   localparam logic [7:0] IDX_MODE = 8'hf0;
   localparam logic [7:0] IDX_OPTION = 8'hf1;
   localparam logic [7:0] IDX_BLANK = 8'hf2;
   // Reset values
   localparam logic [7:0] PAR_MODE_RST = 8'h3c;
   localparam logic [7:0] FLOPPY_ROUTE_RST = 8'h00;
   localparam logic [7:0] SER_MODE_RST = 8'h00;
   localparam logic [7:0] IR_OPT_RST = 8'h02;
   localparam logic [7:0] IR_BLANK_RST = 8'h03;
   // Parallel mode field layout
   localparam int PM_MODE_LSB = 0;
   localparam int PM_THR_LSB = 3;
   localparam int PM_IRQ_TYPE_BIT = 7;
   localparam logic [2:0] PM_PRINTER = 3'h4;
   localparam logic [2:0] PM_SPP = 3'h0;
   localparam logic [2:0] PM_EPP19 = 3'h1;
   localparam logic [2:0] PM_EPP17 = 3'h5;
   localparam logic [2:0] PM_ECP = 3'h2;
   localparam logic [2:0] PM_ECP_EPP19 = 3'h3;
   localparam logic [2:0] PM_ECP_EPP17 = 3'h7;
   // Extended control modes of the ECP engine
   localparam logic [2:0] ECR_PRINTER = 3'h0;
   localparam logic [2:0] ECR_SPP = 3'h1;
   localparam logic [2:0] ECR_FIFO = 3'h2;
   localparam logic [2:0] ECR_ECP = 3'h3;
   localparam logic [2:0] ECR_EPP = 3'h4;
   localparam logic [2:0] ECR_TEST = 3'h6;
   // Floppy routing codes
   localparam logic [1:0] FR_SPLIT = 2'h1;
   localparam logic [1:0] FR_BOTH = 2'h2;
   // Serial mode bits
   localparam int SM_MIDI_BIT = 0;
   localparam int SM_HS_BIT = 1;
   localparam int SM_SHARE_BIT = 7;
   // Infrared option layout
   localparam int IR_RXPOL_BIT = 0;
   localparam int IR_TXPOL_BIT = 1;
   localparam int IR_HALF_BIT = 2;
   localparam int IR_PROTO_LSB = 3;
   localparam int IR_ALT_BIT = 6;
   localparam logic [2:0] IR_PROTO_COM = 3'h0;
   // Writable bit masks; reserved bits read zero
   localparam logic [7:0] FLOPPY_ROUTE_MASK = 8'h03;
   localparam logic [7:0] SER_ONE_MASK = 8'h83;
   localparam logic [7:0] SER_TWO_MASK = 8'h03;
   localparam logic [7:0] IR_OPT_MASK = 8'h7f;
endpackage

/* hw/pmc_regs.sv */
// Port mode configuration registers and the pin logic they steer
`timescale 1ns/100ps
`default_nettype none
module pmc_regs #(
   parameter int STEP_CYCLES = pmc_pkg::BLANK_STEP_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [pmc_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [pmc_pkg::DAT_W-1:0] dat_i,
   output logic [pmc_pkg::DAT_W-1:0] dat_o,
   output logic ack_o,
   // Hard reset from the host bus, pin
   input wire logic host_bus_reset_n_i,
   // Parallel port
   input wire logic printer_acknowledge_n_i,
   input wire logic pp_irq_req_i,
   input wire logic [2:0] ecr_mode_i,
   output logic [2:0] pp_mode_o,
   output logic [3:0] ecp_fifo_threshold_o,
   output logic pp_irq_o,
   output logic pp_irq_oe_o,
   output logic floppy_on_printer_pins_select_o,
   output logic split_drive_routing_o,
   output logic both_drives_on_printer_pins_o,
   // Serial ports
   input wire logic uart1_irq_i,
   input wire logic uart2_irq_i,
   output logic uart1_irq_o,
   output logic uart2_irq_o,
   output logic uart1_midi_o,
   output logic uart1_high_speed_o,
   output logic uart2_midi_o,
   output logic uart2_high_speed_o,
   // Infrared
   input wire logic ir_tx_data_i,
   input wire logic ir_tx_active_i,
   output logic ir_rx_data_o,
   output logic [2:0] ir_protocol_o,
   output logic ir_half_duplex_o,
   input wire logic uart_two_receive_pin_i,
   input wire logic alt_infrared_receive_pin_i,
   output logic uart_two_transmit_pin_o,
   output logic alt_infrared_transmit_pin_o
);
   import pmc_pkg::*;

   localparam int CNT_W = $clog2(STEP_CYCLES + 1);
   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

   // Synchronised pins
   logic host_rst_n_s;
   logic ack_n_s;
   logic rxd_s;
   logic alt_rx_s;

   pmc_sync3 #(.RST_VAL(1'b1)) u_sync_hrst (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(host_bus_reset_n_i), .sync_o(host_rst_n_s));
   pmc_sync3 #(.RST_VAL(1'b1)) u_sync_ack (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(printer_acknowledge_n_i), .sync_o(ack_n_s));
   pmc_sync3 #(.RST_VAL(1'b1)) u_sync_rxd (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(uart_two_receive_pin_i), .sync_o(rxd_s));
   pmc_sync3 #(.RST_VAL(1'b0)) u_sync_alt (
      .clk_i(clk_i), .rst_i(rst_i), .async_i(alt_infrared_receive_pin_i), .sync_o(alt_rx_s));

   // Hard reset: power-on via rst_i or host bus reset; there is no soft reset path at all
   wire hard_rst = rst_i | ~host_rst_n_s;

   // Register storage
   logic [7:0] par_mode_reg;
   logic [7:0] floppy_route_reg;
   logic [7:0] ser_one_reg;
   logic [7:0] ser_two_reg;
   logic [7:0] ir_opt_reg;
   logic [7:0] ir_blank_reg;
   logic ack_reg;
   logic [DAT_W-1:0] dat_reg;

   // Address decode
   wire [7:0] ldn = adr_i[17:10];
   wire [7:0] idx = adr_i[9:2];
   wire req = cyc_i & stb_i & ~ack_reg;
   wire wr = cyc_i & stb_i & ack_reg & we_i & sel_i[0];
   wire hit_par_mode = (ldn == LDN_PARALLEL) && (idx == IDX_MODE);
   wire hit_floppy = (ldn == LDN_PARALLEL) && (idx == IDX_OPTION);
   wire hit_ser_one = (ldn == LDN_SERIAL_ONE) && (idx == IDX_MODE);
   wire hit_ser_two = (ldn == LDN_SERIAL_TWO) && (idx == IDX_MODE);
   wire hit_ir_opt = (ldn == LDN_SERIAL_TWO) && (idx == IDX_OPTION);
   wire hit_ir_blank = (ldn == LDN_SERIAL_TWO) && (idx == IDX_BLANK);
   wire [7:0] wbyte = dat_i[7:0];

   // Read mux; unmapped addresses read zero
   wire [7:0] rd_byte = hit_par_mode ? par_mode_reg :
                        hit_floppy ? floppy_route_reg :
                        hit_ser_one ? ser_one_reg :
                        hit_ser_two ? ser_two_reg :
                        hit_ir_opt ? ir_opt_reg :
                        hit_ir_blank ? ir_blank_reg : 8'h00;

   // Bus answer one cycle after the request, every address acknowledged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= req;
         dat_reg <= req ? {24'h000000, rd_byte} : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         par_mode_reg <= PAR_MODE_RST;
         floppy_route_reg <= FLOPPY_ROUTE_RST;
         ser_one_reg <= SER_MODE_RST;
      end else begin
         if (wr && hit_par_mode) begin
            par_mode_reg <= wbyte;
         end
         if (wr && hit_floppy) begin
            floppy_route_reg <= wbyte & FLOPPY_ROUTE_MASK;
         end
         if (wr && hit_ser_one) begin
            ser_one_reg <= wbyte & SER_ONE_MASK;
         end
      end
   end

   // second serial port cleared by host bus reset
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         ser_two_reg <= SER_MODE_RST;
         ir_opt_reg <= IR_OPT_RST;
         ir_blank_reg <= IR_BLANK_RST;
      end else begin
         if (wr && hit_ser_two) begin
            ser_two_reg <= wbyte & SER_TWO_MASK;
         end
         if (wr && hit_ir_opt) begin
            ir_opt_reg <= wbyte & IR_OPT_MASK;
         end
         if (wr && hit_ir_blank) begin
            ir_blank_reg <= wbyte;
         end
      end
   end

   // Parallel mode decode
   wire [2:0] pmode = par_mode_reg[PM_MODE_LSB +: 3];
   wire pulsed_type = par_mode_reg[PM_IRQ_TYPE_BIT];
   wire ecp_family = (pmode == PM_ECP) || (pmode == PM_ECP_EPP19) || (pmode == PM_ECP_EPP17);
   wire basic_mode = (pmode == PM_PRINTER) || (pmode == PM_SPP);
   // level interrupt in FIFO, ECP and TEST engine modes
   wire level_irq = ecp_family &&
                    ((ecr_mode_i == ECR_FIFO) || (ecr_mode_i == ECR_ECP) || (ecr_mode_i == ECR_TEST));
   // type bit has no say in printer or SPP
   wire use_pulse = pulsed_type && !basic_mode && !level_irq;

   logic req_d_reg;
   logic pp_irq_reg;
   logic pp_irq_oe_reg;
   wire req_rise = pp_irq_req_i & ~req_d_reg;

   // following the request when level, pulsed low then released, or following acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_d_reg <= 1'b0;
         pp_irq_reg <= 1'b1;
         pp_irq_oe_reg <= 1'b0;
      end else begin
         req_d_reg <= pp_irq_req_i;
         if (level_irq) begin
            pp_irq_reg <= pp_irq_req_i;
            pp_irq_oe_reg <= 1'b1;
         end else if (use_pulse) begin
            pp_irq_reg <= ~req_rise;
            pp_irq_oe_reg <= req_rise;
         end else begin
            pp_irq_reg <= ack_n_s;
            pp_irq_oe_reg <= 1'b1;
         end
      end
   end

   wire [1:0] froute = floppy_route_reg[1:0];
   logic split_reg;
   logic both_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         split_reg <= 1'b0;
         both_reg <= 1'b0;
      end else begin
         split_reg <= (froute == FR_SPLIT);
         both_reg <= (froute == FR_BOTH);
      end
   end

   // with the share bit set, both lines assert when either UART requests
   wire share = ser_one_reg[SM_SHARE_BIT];
   logic u1_irq_reg;
   logic u2_irq_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         u1_irq_reg <= 1'b0;
         u2_irq_reg <= 1'b0;
      end else begin
         u1_irq_reg <= uart1_irq_i | (share & uart2_irq_i);
         u2_irq_reg <= uart2_irq_i | (share & uart1_irq_i);
      end
   end

   // Infrared option decode
   wire rx_pol = ir_opt_reg[IR_RXPOL_BIT];
   wire tx_pol = ir_opt_reg[IR_TXPOL_BIT];
   wire half = ir_opt_reg[IR_HALF_BIT];
   wire [2:0] proto = ir_opt_reg[IR_PROTO_LSB +: 3];
   wire alt_pins = ir_opt_reg[IR_ALT_BIT];
   wire ir_on = (proto != IR_PROTO_COM);

   // blanking timer: whole steps left and cycles within the current step
   logic [7:0] steps_reg;
   logic [CNT_W-1:0] tick_reg;
   logic tx_d_reg;
   wire tx_end = tx_d_reg & ~ir_tx_active_i;
   wire blanking = half & ir_on & (ir_tx_active_i | tx_end | (steps_reg != 8'h00));

   // each step lasts 100 us; zero blanks during transmit and the one cycle after it
   // timer also cleared by host bus reset
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         steps_reg <= 8'h00;
         tick_reg <= '0;
         tx_d_reg <= 1'b0;
      end else begin
         tx_d_reg <= ir_tx_active_i;
         if (ir_tx_active_i || tx_end) begin
            steps_reg <= ir_tx_active_i ? 8'h00 : ir_blank_reg;
            tick_reg <= '0;
         end else if (steps_reg != 8'h00) begin
            tick_reg <= (tick_reg == STEP_LAST) ? '0 : tick_reg + 1'b1;
            if (tick_reg == STEP_LAST) begin
               steps_reg <= steps_reg - 8'h01;
            end
         end
      end
   end

   // receive polarity applied in infrared protocols
   wire rx_pin = alt_pins ? alt_rx_s : rxd_s;
   wire rx_logical = ir_on ? (rx_pin ^ rx_pol) : rx_pin;
   // Value when blanked is 0, since blanking needs ir_on; the UART sees that low line level as a start bit
   wire rx_idle = ~ir_on;
   // transmit polarity inverts the driven line in infrared protocols only
   wire tx_line = ir_on ? (ir_tx_data_i ^ tx_pol) : ir_tx_data_i;
   wire tx_idle = ir_on ? tx_pol : 1'b1;

   logic rx_out_reg;
   logic txd_reg;
   logic alt_tx_reg;
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         rx_out_reg <= 1'b1;
         txd_reg <= 1'b1;
         alt_tx_reg <= IR_OPT_RST[IR_TXPOL_BIT];
      end else begin
         rx_out_reg <= blanking ? rx_idle : rx_logical;
         txd_reg <= (alt_pins && ir_on) ? 1'b1 : tx_line;
         alt_tx_reg <= (alt_pins && ir_on) ? tx_line : tx_idle;
      end
   end

   // Output wiring, all from flip-flops; floppy_on_printer_pins_select_o is the OR of split_reg and both_reg
   assign dat_o = dat_reg;
   assign ack_o = ack_reg;
   assign pp_mode_o = par_mode_reg[PM_MODE_LSB +: 3];
   assign ecp_fifo_threshold_o = par_mode_reg[PM_THR_LSB +: 4];
   assign pp_irq_o = pp_irq_reg;
   assign pp_irq_oe_o = pp_irq_oe_reg;
   assign floppy_on_printer_pins_select_o = split_reg | both_reg;
   assign split_drive_routing_o = split_reg;
   assign both_drives_on_printer_pins_o = both_reg;
   assign uart1_irq_o = u1_irq_reg;
   assign uart2_irq_o = u2_irq_reg;
   assign uart1_midi_o = ser_one_reg[SM_MIDI_BIT];
   assign uart2_midi_o = ser_two_reg[SM_MIDI_BIT];
   assign uart1_high_speed_o = ser_one_reg[SM_HS_BIT];
   assign uart2_high_speed_o = ser_two_reg[SM_HS_BIT];
   assign ir_protocol_o = ir_opt_reg[IR_PROTO_LSB +: 3];
   assign ir_half_duplex_o = ir_opt_reg[IR_HALF_BIT];
   assign ir_rx_data_o = rx_out_reg;
   assign uart_two_transmit_pin_o = txd_reg;
   assign alt_infrared_transmit_pin_o = alt_tx_reg;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   par_reset_val_a: assert property ($past(hard_rst) |-> par_mode_reg == PAR_MODE_RST)
      else $error("parallel mode not at reset value");
   ir_reset_val_a: assert property ($past(hard_rst) |-> ir_opt_reg == IR_OPT_RST && ir_blank_reg == IR_BLANK_RST)
      else $error("infrared options not at reset value");
   bus_ack_once_a: assert property (ack_o |=> !ack_o)
      else $error("ack held two cycles");
   mode_write_a: assert property (wr && hit_par_mode && !hard_rst |=> pp_mode_o == $past(wbyte[2:0]))
      else $error("mode field did not take write");
   share_both_a: assert property (share && uart1_irq_i && !$past(rst_i) |=> uart2_irq_o)
      else $error("shared interrupt not on second line");
   no_share_a: assert property (!share && !uart1_irq_i |=> !uart2_irq_o || $past(uart2_irq_i))
      else $error("second line raised without cause");
   level_drive_a: assert property (level_irq |=> pp_irq_oe_o)
      else $error("level interrupt not driven");
   pulse_short_a: assert property (pp_irq_oe_o && !pp_irq_o && $past(use_pulse) |=> !pp_irq_oe_o || !$past(use_pulse))
      else $error("pulsed interrupt driven too long");
   basic_follow_a: assert property (basic_mode && $stable(ack_n_s) |=> pp_irq_oe_o && pp_irq_o == $past(ack_n_s))
      else $error("printer mode interrupt does not follow acknowledge");
   blank_rx_a: assert property (half && ir_on && ir_tx_active_i |=> ir_rx_data_o == 1'b0)
      else $error("receiver not blanked during transmit");
   split_route_a: assert property (froute == FR_SPLIT |=> split_drive_routing_o && !both_drives_on_printer_pins_o)
      else $error("split routing not decoded");

   cov_pulse: cover property (use_pulse && req_rise);
   cov_share: cover property (share && uart2_irq_i);
   cov_blank_end: cover property (blanking ##1 !blanking);
   cov_level: cover property (level_irq && pp_irq_req_i);
endmodule
`default_nettype wire

/* hw/pmc_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pmc_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic out_reg;

   // First stage feeds only the second; output moves once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         out_reg <= RST_VAL;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
         end
      end
   end

   assign sync_o = out_reg;
endmodule
`default_nettype wire

/* test/test_pmc_regs.sv */
// Self-checking bench for the port mode configuration register bank
`timescale 1ns/100ps
`default_nettype none
module test_pmc_regs;
   import pmc_pkg::*;
   localparam int STEP = 10;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hrst_n = 1'b1, ack_n = 1'b1, pp_req = 1'b0;
   logic u1 = 1'b0, u2 = 1'b0, tx_d = 1'b0, tx_act = 1'b0, rx_pin = 1'b1, alt_rx = 1'b1;
   logic [ADR_W-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [DAT_W-1:0] dat = '0, dat_o;
   logic [2:0] ecr = 3'h0, pmode, proto;
   logic [3:0] thr;
   logic ack, irq, irq_oe, fsel, fsplit, fboth, u1_o, u2_o, m1, h1, m2, h2, rx_o, half, txd, alt_tx;
   int errors = 0, check_count = 0;
   pmc_regs #(.STEP_CYCLES(STEP)) dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .host_bus_reset_n_i(hrst_n),
      .printer_acknowledge_n_i(ack_n), .pp_irq_req_i(pp_req), .ecr_mode_i(ecr), .pp_mode_o(pmode),
      .ecp_fifo_threshold_o(thr), .pp_irq_o(irq), .pp_irq_oe_o(irq_oe), .floppy_on_printer_pins_select_o(fsel),
      .split_drive_routing_o(fsplit), .both_drives_on_printer_pins_o(fboth), .uart1_irq_i(u1), .uart2_irq_i(u2),
      .uart1_irq_o(u1_o), .uart2_irq_o(u2_o), .uart1_midi_o(m1), .uart1_high_speed_o(h1), .uart2_midi_o(m2),
      .uart2_high_speed_o(h2), .ir_tx_data_i(tx_d), .ir_tx_active_i(tx_act), .ir_rx_data_o(rx_o),
      .ir_protocol_o(proto), .ir_half_duplex_o(half), .uart_two_receive_pin_i(rx_pin),
      .alt_infrared_receive_pin_i(alt_rx), .uart_two_transmit_pin_o(txd), .alt_infrared_transmit_pin_o(alt_tx));
   // Free-running 50 MHz clock
   always #10 clk = ~clk;
   // Prints the counts and the verdict, then stops
   task automatic close_out();
      $display("Counts: %0d checks, %0d mismatches", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_word(input string name, input logic [DAT_W-1:0] exp, input logic [DAT_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_pin(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One classic cycle: hold everything until ack is sampled, then release
   task automatic bus(input logic wr, input logic [ADR_W-1:0] a, input logic [3:0] s, input logic [7:0] d,
                      output logic [DAT_W-1:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      sel <= s;
      dat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_o;
      if (ack !== 1'b1) begin
         errors++;
         $display("BAD bus ack expected 1 seen %b", ack);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
      logic [DAT_W-1:0] q;
      bus(1'b1, a, 4'hf, d, q);
   endtask
   task automatic rd_chk(input string name, input logic [ADR_W-1:0] a, input logic [7:0] exp);
      logic [DAT_W-1:0] q;
      bus(1'b0, a, 4'hf, 8'h00, q);
      chk_word(name, {24'h0, exp}, q);
   endtask
   // Outputs are looked at mid-cycle, clear of the launching edge
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic t_defaults();
      rd_chk("par_mode", 18'h0fc0, PAR_MODE_RST);
      rd_chk("floppy", 18'h0fc4, 8'h00);
      rd_chk("ser1", 18'h13c0, 8'h00);
      rd_chk("ser2", 18'h17c0, 8'h00);
      rd_chk("ir_opt", 18'h17c4, 8'h02);
      rd_chk("blank", 18'h17c8, 8'h03);
      idle(1);
      chk_pin("pmode", 8'h04, {5'h0, pmode});
      chk_pin("thr", 8'h07, {4'h0, thr});
      chk_pin("ser bits", 8'h00, {4'h0, m1, h1, m2, h2});
      chk_pin("ir half", 8'h00, {4'h0, half, proto});
      $display("test defaults done");
   endtask
   // reserved bits dropped, masked writes and unmapped reads
   task automatic t_masks();
      logic [DAT_W-1:0] q;
      wr(18'h0fc0, 8'hff);
      wr(18'h0fc4, 8'hff);
      wr(18'h13c0, 8'hff);
      wr(18'h17c0, 8'hff);
      wr(18'h17c4, 8'hff);
      wr(18'h17c8, 8'hff);
      rd_chk("par_mode ff", 18'h0fc0, 8'hff);
      rd_chk("floppy ff", 18'h0fc4, 8'h03);
      rd_chk("ser1 ff", 18'h13c0, 8'h83);
      rd_chk("ser2 ff", 18'h17c0, 8'h03);
      rd_chk("ir_opt ff", 18'h17c4, 8'h7f);
      rd_chk("blank ff", 18'h17c8, 8'hff);
      bus(1'b1, 18'h17c8, 4'he, 8'h00, q);
      rd_chk("blank nosel", 18'h17c8, 8'hff);
      rd_chk("unmapped", 18'h0000, 8'h00);
      idle(1);
      chk_pin("ser bits ff", 8'h0f, {4'h0, m1, h1, m2, h2});
      $display("test masks done");
   endtask
   task automatic t_hard_reset();
      @(posedge clk);
      hrst_n <= 1'b0;
      idle(10);
      @(posedge clk);
      hrst_n <= 1'b1;
      idle(6);
      t_defaults();
      $display("test hard reset done");
   endtask
   // every mode code and a threshold
   task automatic t_modes();
      logic [2:0] codes [7] = '{PM_PRINTER, PM_SPP, PM_EPP19, PM_EPP17, PM_ECP, PM_ECP_EPP19, PM_ECP_EPP17};
      foreach (codes[i]) begin
         wr(18'h0fc0, {1'b0, 4'ha, codes[i]});
         rd_chk("mode rb", 18'h0fc0, {1'b0, 4'ha, codes[i]});
         idle(1);
         chk_pin("pmode", {5'h0, codes[i]}, {5'h0, pmode});
         chk_pin("thr", 8'h0a, {4'h0, thr});
      end
      $display("test modes done");
   endtask
   task automatic t_floppy();
      logic [2:0] exp [4] = '{3'b000, 3'b110, 3'b101, 3'b000};
      for (int c = 0; c < 4; c++) begin
         wr(18'h0fc4, 8'(c));
         idle(2);
         chk_pin("routing", {5'h0, exp[c]}, {5'h0, fsel, fsplit, fboth});
      end
      $display("test floppy done");
   endtask
   task automatic t_pp_irq();
      logic [7:0] follow [3] = '{8'hbc, 8'hb8, 8'h39};
      logic [2:0] lvl [3] = '{ECR_FIFO, ECR_ECP, ECR_TEST};
      int cnt;
      logic seen;
      foreach (follow[i]) begin
         wr(18'h0fc0, follow[i]);
         @(posedge clk);
         ack_n <= 1'b0;
         idle(8);
         chk_pin("follow lo", 8'h02, {6'h0, irq_oe, irq});
         @(posedge clk);
         ack_n <= 1'b1;
         idle(8);
         chk_pin("follow hi", 8'h03, {6'h0, irq_oe, irq});
      end
      wr(18'h0fc0, 8'h3a);
      foreach (lvl[i]) begin
         @(posedge clk);
         ecr <= lvl[i];
         pp_req <= 1'b1;
         idle(3);
         chk_pin("level hi", 8'h03, {6'h0, irq_oe, irq});
         @(posedge clk);
         pp_req <= 1'b0;
         idle(3);
         chk_pin("level lo", 8'h02, {6'h0, irq_oe, irq});
      end
      @(posedge clk);
      ecr <= ECR_EPP;
      wr(18'h0fc0, 8'hb9);
      idle(3);
      chk_pin("pulse idle", 8'h00, {7'h0, irq_oe});
      cnt = 0;
      seen = 1'b1;
      @(posedge clk);
      pp_req <= 1'b1;
      repeat (12) begin
         idle(1);
         if (irq_oe === 1'b1) begin
            cnt++;
            seen = irq;
         end
      end
      chk_pin("pulse len", 8'h01, 8'(cnt));
      chk_pin("pulse lvl", 8'h00, {7'h0, seen});
      @(posedge clk);
      pp_req <= 1'b0;
      $display("test parallel irq done");
   endtask
   task automatic t_uart();
      wr(18'h13c0, 8'h02);
      wr(18'h17c0, 8'h01);
      idle(1);
      chk_pin("ser bits", 8'h06, {4'h0, m1, h1, m2, h2});
      @(posedge clk);
      u1 <= 1'b1;
      idle(2);
      chk_pin("separate", 8'h02, {6'h0, u1_o, u2_o});
      wr(18'h13c0, 8'h80);
      idle(2);
      chk_pin("shared 1", 8'h03, {6'h0, u1_o, u2_o});
      @(posedge clk);
      u1 <= 1'b0;
      u2 <= 1'b1;
      idle(2);
      chk_pin("shared 2", 8'h03, {6'h0, u1_o, u2_o});
      @(posedge clk);
      u2 <= 1'b0;
      idle(2);
      chk_pin("shared off", 8'h00, {6'h0, u1_o, u2_o});
      $display("test uart done");
   endtask
   task automatic t_ir();
      chk_pin("com tx lo", 8'h00, {7'h0, txd});
      @(posedge clk);
      tx_d <= 1'b1;
      idle(2);
      chk_pin("com tx", 8'h01, {7'h0, txd});
      wr(18'h17c4, 8'h0a);
      idle(8);
      chk_pin("irda tx rx", 8'h05, {3'h0, proto, txd, rx_o});
      wr(18'h17c4, 8'h0b);
      idle(8);
      chk_pin("rx inv", 8'h00, {7'h0, rx_o});
      @(posedge clk);
      alt_rx <= 1'b0;
      wr(18'h17c4, 8'h48);
      idle(8);
      chk_pin("alt pins", 8'h06, {5'h0, alt_tx, txd, rx_o});
      @(posedge clk);
      alt_rx <= 1'b1;
      wr(18'h17c8, 8'h02);
      wr(18'h17c4, 8'h0c);
      idle(8);
      chk_pin("half idle", 8'h03, {6'h0, half, rx_o});
      @(posedge clk);
      tx_act <= 1'b1;
      idle(4);
      chk_pin("blank tx", 8'h00, {7'h0, rx_o});
      @(posedge clk);
      tx_act <= 1'b0;
      idle(12);
      chk_pin("blank after", 8'h00, {7'h0, rx_o});
      idle(16);
      chk_pin("blank over", 8'h01, {7'h0, rx_o});
      $display("test infrared done");
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("BAD watchdog expected done seen timeout");
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      idle(6);
      t_defaults();
      t_masks();
      t_hard_reset();
      t_modes();
      t_floppy();
      t_pp_irq();
      t_uart();
      t_ir();
      close_out();
   end
endmodule
`default_nettype wire
